/* src/parallel_io_controller.sv */
/*
  Parallel I/O controller: 32 lines, ownership mux between controller
  and peripherals, direction, level, filter and change-event registers.
  Assumes an AXI4-Lite master on aclk and an external pad ring that
  resolves pin levels from the output and enable signals.
*/
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Thirty-two lines; six dedicated, the rest shared with peripherals.
// - Reset: controller owns lines as inputs, except listed peripheral-owned ones.
// - Owner enable gives line to controller, disable to peripheral; status shows owner.
// - Dedicated lines ignore owner commands and always read owned.
// - Controller-owned line drives the peripheral's input to zero.
// - Output enable/disable commands set and clear direction, readable in status.
// - Direction reaches the pin only while the controller owns it.
// - Set/clear commands drive owned outputs high/low; value readable.
// - Owned non-output lines are not driven by the controller.
// - Peripheral-owned lines take level and direction from the peripheral.
// - Pin status always returns actual pin levels.
// - Filter enable/disable per line, status readable, applies to any owner.
// - Interrupt enable/disable set and clear the readable mask.
// - Any pin level change sets its event bit, regardless of mode.
// - Interrupt asserted while any event bit and mask bit are both set.
// - Reading the event status register clears it.
// - All registers 32 bits; each line owns a fixed bit.
// - Undefined line bits ignore writes and read zero.
// - Line n always uses bit n in every register.
module parallel_io_controller
  import pio_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [pio_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [pio_ctrl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [pio_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [pio_ctrl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [pio_ctrl_pkg::LINES-1:0] pin_in,
  output logic [pio_ctrl_pkg::LINES-1:0] pin_out,
  output logic [pio_ctrl_pkg::LINES-1:0] pin_oe,
  // Peripheral side of shared lines
  input wire logic [pio_ctrl_pkg::LINES-1:0] periph_out,
  input wire logic [pio_ctrl_pkg::LINES-1:0] periph_oe,
  output logic [pio_ctrl_pkg::LINES-1:0] periph_in,
  // Interrupt to the interrupt controller
  output logic change_irq
);
  import pio_ctrl_pkg::*;

  // Apply a set/clear command pair to a status word
  function automatic logic [LINES-1:0] set_clr(
    input logic [LINES-1:0] cur,
    input logic [LINES-1:0] set_bits,
    input logic [LINES-1:0] clr_bits
  );
    set_clr = (cur | set_bits) & ~clr_bits;
  endfunction : set_clr

  // Byte-strobe merge of write data, undefined lines masked
  function automatic logic [LINES-1:0] strobed(
    input logic [DATA_W-1:0] data,
    input logic [3:0] strb
  );
    logic [LINES-1:0] m;
    m = ZERO_WORD;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    strobed = m & DEFINED_MASK;
  endfunction : strobed

  // Write channel capture
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [LINES-1:0] wr_bits;
  logic wr_hit;

  // Control and status state
  logic [LINES-1:0] owner;
  logic [LINES-1:0] out_dir;
  logic [LINES-1:0] out_level;
  logic [LINES-1:0] filt_on;
  logic [LINES-1:0] irq_mask;
  logic [LINES-1:0] event_stat;
  logic [LINES-1:0] pin_clean;
  logic [LINES-1:0] pin_prev;
  logic [LINES-1:0] change;
  logic evt_read;
  logic [LINES-1:0] next_pin_out;
  logic [LINES-1:0] next_pin_oe;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_bits = strobed(w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Ready only while the slot is empty, so one write is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_comb begin
    case (aw_addr)
      OFF_OWNER_EN, OFF_OWNER_DIS, OFF_OUT_EN, OFF_OUT_DIS, OFF_FILT_EN,
      OFF_FILT_DIS, OFF_LVL_SET, OFF_LVL_CLR, OFF_IRQ_EN, OFF_IRQ_DIS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Write commands: one per address, never two on the same state
  function automatic logic [LINES-1:0] cmd(input logic [ADDR_W-1:0] off);
    cmd = (wr_fire && aw_addr == off) ? wr_bits : ZERO_WORD;
  endfunction : cmd

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      owner <= OWNER_RESET;
    end else begin
      owner <= set_clr(owner, cmd(OFF_OWNER_EN), cmd(OFF_OWNER_DIS)) | DEDICATED_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_dir <= ZERO_WORD;
    end else begin
      out_dir <= set_clr(out_dir, cmd(OFF_OUT_EN), cmd(OFF_OUT_DIS));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_level <= ZERO_WORD;
    end else begin
      out_level <= set_clr(out_level, cmd(OFF_LVL_SET), cmd(OFF_LVL_CLR));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_on <= ZERO_WORD;
    end else begin
      filt_on <= set_clr(filt_on, cmd(OFF_FILT_EN), cmd(OFF_FILT_DIS));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= ZERO_WORD;
    end else begin
      irq_mask <= set_clr(irq_mask, cmd(OFF_IRQ_EN), cmd(OFF_IRQ_DIS));
    end
  end

  // Pin side
  pin_glitch_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(pin_in),
    .filter_on(filt_on),
    .pin_clean(pin_clean)
  );

  // Pad mux; registered so pads never see a decode glitch
  always_comb begin
    next_pin_oe = (owner & out_dir) | (~owner & periph_oe);
    next_pin_out = (owner & out_level) | (~owner & periph_out);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe <= ZERO_WORD;
      pin_out <= ZERO_WORD;
    end else begin
      pin_oe <= next_pin_oe;
      pin_out <= next_pin_out;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_in <= ZERO_WORD;
    end else begin
      periph_in <= pin_clean & ~owner;
    end
  end

  // Change detection; first sample after reset taken without an event
  logic prev_valid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= ZERO_WORD;
      prev_valid <= 1'b0;
    end else begin
      pin_prev <= pin_clean;
      prev_valid <= 1'b1;
    end
  end

  assign change = prev_valid ? (pin_clean ^ pin_prev) : ZERO_WORD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_stat <= ZERO_WORD;
    end else if (evt_read) begin
      event_stat <= change;
    end else begin
      event_stat <= event_stat | change;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_irq <= 1'b0;
    end else begin
      change_irq <= |(event_stat & irq_mask & ~{LINES{evt_read}}) || |(change & irq_mask);
    end
  end

  // Read channel: one-cycle latency, held until rready
  logic [DATA_W-1:0] next_rdata;
  logic next_rok;
  logic rd_fire;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign evt_read = rd_fire && s_axi_araddr == OFF_EVT_STAT;

  always_comb begin
    next_rok = 1'b1;
    case (s_axi_araddr)
      OFF_OWNER_STAT: next_rdata = owner;
      OFF_OUT_STAT: next_rdata = out_dir;
      OFF_FILT_STAT: next_rdata = filt_on;
      OFF_LVL_STAT: next_rdata = out_level;
      OFF_PIN_STAT: next_rdata = pin_clean;
      OFF_IRQ_MASK: next_rdata = irq_mask;
      OFF_EVT_STAT: next_rdata = event_stat;
      OFF_OWNER_EN, OFF_OWNER_DIS, OFF_OUT_EN, OFF_OUT_DIS, OFF_FILT_EN,
      OFF_FILT_DIS, OFF_LVL_SET, OFF_LVL_CLR, OFF_IRQ_EN, OFF_IRQ_DIS: next_rdata = ZERO_WORD;
      default: begin
        next_rdata = ZERO_WORD;
        next_rok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata & DEFINED_MASK;
      s_axi_rresp <= next_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : parallel_io_controller
`default_nettype wire

/* include/pio_ctrl_pkg.sv */
/*
  Package for the parallel I/O controller: register offsets, reset
  values, line grouping masks.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned offsets.
*/
package pio_ctrl_pkg;
  localparam int LINES = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFF_OWNER_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OWNER_DIS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OWNER_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OUT_EN = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OUT_DIS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_OUT_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FILT_EN = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_FILT_DIS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_FILT_STAT = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_LVL_SET = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_LVL_CLR = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_LVL_STAT = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_PIN_STAT = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_IRQ_DIS = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 8'h4c;

  // Lines 16-19, 23, 24 have no peripheral behind them
  localparam logic [LINES-1:0] DEDICATED_MASK = 32'h0188_0000 | 32'h000f_0000;
  // Lines 25-31 start owned by their peripheral
  localparam logic [LINES-1:0] OWNER_RESET = 32'h01ff_ffff;
  localparam logic [LINES-1:0] DEFINED_MASK = 32'hffff_ffff;
  localparam logic [LINES-1:0] ZERO_WORD = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pio_ctrl_pkg

/* src/pin_glitch_filter.sv */
/*
  Per-line input synchroniser and glitch filter.
  Assumes pins are asynchronous to aclk; output is synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_glitch_filter
  import pio_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Lines
  input wire logic [pio_ctrl_pkg::LINES-1:0] pin_raw,
  input wire logic [pio_ctrl_pkg::LINES-1:0] filter_on,
  output logic [pio_ctrl_pkg::LINES-1:0] pin_clean
);
  logic [LINES-1:0] sync_a;
  logic [LINES-1:0] sync_b;
  logic [LINES-1:0] sync_c;

  // Runs through reset so pin status shows the pins at release
  always_ff @(posedge aclk) begin
    sync_a <= pin_raw;
    sync_b <= sync_a;
    sync_c <= sync_b;
  end

  // Filtered lines only follow a level that held two samples running;
  // bypassed in reset, so no false level change follows the release
  always_ff @(posedge aclk) begin
    for (int i = 0; i < LINES; i++) begin
      if (!aresetn || !filter_on[i]) begin
        pin_clean[i] <= sync_b[i];
      end else if (sync_b[i] == sync_c[i]) begin
        pin_clean[i] <= sync_b[i];
      end
    end
  end
endmodule : pin_glitch_filter
`default_nettype wire

/* verification/pio_ctrl_props.sv */
/* Checker on the controller's bus, pin and interrupt ports.
   Assumes it is bound onto every controller instance. */
`timescale 1ns/10ps
`default_nettype none
module pio_ctrl_props
  import pio_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pio_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Lines and interrupt
  input wire logic [pio_ctrl_pkg::LINES-1:0] pin_in,
  input wire logic [pio_ctrl_pkg::LINES-1:0] periph_in,
  input wire logic change_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [pio_ctrl_pkg::LINES-1:0] last_pin;
  logic [2:0] quiet;
  // Pins settled long enough that no event is still in flight
  always_ff @(posedge aclk) begin
    last_pin <= pin_in;
    if (!aresetn || pin_in != last_pin) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
  sequence w_take; s_axi_wvalid && s_axi_wready; endsequence
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  wr_answer_a: assert property (aw_take ##[0:3] w_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (ar_take |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  b_release_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("response dropped without bready");
  r_release_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped without rready");
  ded_input_a: assert property ((periph_in & DEDICATED_MASK) == ZERO_WORD)
    else $error("dedicated line leaks to peripheral");
  clr_read_a: assert property (
    ar_take ##0 (s_axi_araddr == OFF_EVT_STAT && quiet == 3'h7) |-> ##[1:3] !change_irq)
    else $error("interrupt kept after status read");
endmodule : pio_ctrl_props
bind parallel_io_controller pio_ctrl_props chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .pin_in, .periph_in, .change_irq);
`default_nettype wire

/* verification/pad_ring_model.sv */
/* Pad and external circuit model for the controller pins.
   Assumes the bench gives a level for every line nobody drives. */
`timescale 1ns/10ps
`default_nettype none
module pad_ring_model
  import pio_ctrl_pkg::*;
(
  // Device drive
  input wire logic [pio_ctrl_pkg::LINES-1:0] pin_out,
  input wire logic [pio_ctrl_pkg::LINES-1:0] pin_oe,
  // External circuit
  input wire logic [pio_ctrl_pkg::LINES-1:0] ext_level,
  output logic [pio_ctrl_pkg::LINES-1:0] pin_in
);
  // Undriven lines follow the external circuit, never the last drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pad_ring_model
`default_nettype wire

/* verification/parallel_io_controller_tb_top.sv */
/* Directed bench for the parallel I/O controller.
   Assumes the package map and a 100 MHz aclk. */
`timescale 1ns/10ps
`default_nettype none
module parallel_io_controller_tb_top;
  import pio_ctrl_pkg::*;
  logic aclk, aresetn, change_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in, ext_level;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  logic [7:0] sa [7] = '{OFF_OWNER_STAT, OFF_OUT_STAT, OFF_FILT_STAT, OFF_LVL_STAT,
    OFF_IRQ_MASK, OFF_EVT_STAT, OFF_PIN_STAT};
  logic [31:0] se [7] = '{OWNER_RESET, 0, 0, 0, 0, 0, 32'h0050_1234};
  parallel_io_controller dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .periph_out,
    .periph_oe, .periph_in, .change_irq);
  pad_ring_model pads (.pin_out, .pin_oe, .ext_level, .pin_in);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Ceiling well above the two hundred or so cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ap, wp;
    ap = 1;
    wp = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ap && s_axi_awready) begin
        ap = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready) begin
        wp = 0;
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a);
    chk($sformatf("reg %h", a), e, rv);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rr});
  endtask : rdc
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
    {periph_out, periph_oe} = 64'h0;
    ext_level = 32'h0050_1234;
    tick(10);
    aresetn <= 1'b1;
    foreach (sa[i]) rdc(sa[i], se[i], RESP_OKAY);
    rdc(OFF_OWNER_EN, ZERO_WORD, RESP_OKAY);
    rdc(8'h0c, ZERO_WORD, RESP_SLVERR);
    wr(8'h1c, 32'hffff_ffff, RESP_SLVERR);
    wr(OFF_OWNER_DIS, 32'hffff_ffff, RESP_OKAY);
    rdc(OFF_OWNER_STAT, DEDICATED_MASK, RESP_OKAY);
    wr(OFF_OWNER_EN, 32'h0000_ffff, RESP_OKAY);
    rdc(OFF_OWNER_STAT, 32'h018f_ffff, RESP_OKAY);
    periph_out <= 32'ha500_0000;
    periph_oe <= 32'hff00_0000;
    wr(OFF_OUT_EN, 32'hffff_ffff, RESP_OKAY);
    rdc(OFF_OUT_STAT, 32'hffff_ffff, RESP_OKAY);
    wr(OFF_LVL_SET, 32'h0000_00ff, RESP_OKAY);
    wr(OFF_LVL_CLR, 32'h0000_000f, RESP_OKAY);
    rdc(OFF_LVL_STAT, 32'h0000_00f0, RESP_OKAY);
    tick(4);
    chk("pin_oe", 32'hff8f_ffff, pin_oe);
    chk("pin_out", 32'ha400_00f0, pin_out);
    chk("periph_in", 32'ha450_0000, periph_in);
    rdc(OFF_PIN_STAT, 32'ha450_00f0, RESP_OKAY);
    wr(OFF_OUT_DIS, 32'hffff_ffff, RESP_OKAY);
    tick(10);
    chk("pin_oe", 32'hfe00_0000, pin_oe);
    rd(OFF_EVT_STAT);
    wr(OFF_IRQ_EN, 32'h0000_0100, RESP_OKAY);
    rdc(OFF_IRQ_MASK, 32'h0000_0100, RESP_OKAY);
    ext_level <= ext_level ^ 32'h0000_0300;
    tick(10);
    chk("change_irq", 32'h1, {31'h0, change_irq});
    rdc(OFF_EVT_STAT, 32'h0000_0300, RESP_OKAY);
    rdc(OFF_EVT_STAT, ZERO_WORD, RESP_OKAY);
    chk("change_irq", ZERO_WORD, {31'h0, change_irq});
    wr(OFF_IRQ_DIS, 32'h0000_0100, RESP_OKAY);
    ext_level <= ext_level ^ 32'h0000_0100;
    tick(10);
    chk("change_irq", ZERO_WORD, {31'h0, change_irq});
    rdc(OFF_EVT_STAT, 32'h0000_0100, RESP_OKAY);
    wr(OFF_FILT_EN, 32'h0000_0400, RESP_OKAY);
    rdc(OFF_FILT_STAT, 32'h0000_0400, RESP_OKAY);
    // One-cycle pulse on a filtered and an unfiltered line
    @(posedge aclk);
    ext_level <= ext_level ^ 32'h0000_0c00;
    @(posedge aclk);
    ext_level <= ext_level ^ 32'h0000_0c00;
    tick(10);
    rdc(OFF_EVT_STAT, 32'h0000_0800, RESP_OKAY);
    wr(OFF_FILT_DIS, 32'h0000_0400, RESP_OKAY);
    rdc(OFF_FILT_STAT, ZERO_WORD, RESP_OKAY);
    // Change timed to reach the event bit at the clearing read's edge
    @(posedge aclk);
    ext_level <= ext_level ^ 32'h0000_1000;
    tick(2);
    rdc(OFF_EVT_STAT, ZERO_WORD, RESP_OKAY);
    rdc(OFF_EVT_STAT, 32'h0000_1000, RESP_OKAY);
    close_out();
  end
endmodule : parallel_io_controller_tb_top
`default_nettype wire
